// ---- rtl/tbk_pkg.sv ----
// Register map, field positions, reset values and counts of the timer bank.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package tbk_pkg;
  // Timer n: low counter at 8*n, high counter at 8*n+4
  localparam logic [7:0] TBK_TMR_LAST = 8'h3c;
  localparam logic [7:0] TBK_CTRL = 8'h40;
  localparam logic [7:0] TBK_TEN = 8'h44;
  localparam logic [7:0] TBK_TFL = 8'h48;
  localparam logic [7:0] TBK_EFL = 8'h4c;
  localparam logic [7:0] TBK_SFL = 8'h50;
  localparam logic [7:0] TBK_TMK = 8'h54;
  localparam logic [7:0] TBK_EMK = 8'h58;
  localparam logic [7:0] TBK_SMK = 8'h5c;
  localparam logic [7:0] TBK_STAT = 8'h60;
  localparam logic [7:0] TBK_WAIT = 8'h64;
  // Control bits
  localparam int TBK_CTRL_SRC_BIT = 0;
  localparam int TBK_CTRL_EMU_BIT = 3;
  // Level request flag sits in the edge flag register
  localparam int TBK_LVL_BIT = 6;
  // Edge inputs 0..3 react to rising edges, 4..5 to falling
  localparam logic [5:0] TBK_EDGE_POS = 6'h0f;
  localparam logic [7:0] TBK_REG_RST = 8'h00;
  localparam logic [1:0] TBK_WDOG_LOW_CYC = 2'h2;
  localparam logic [3:0] TBK_BAUD_LAST = 4'hf;
  localparam logic [2:0] TBK_FDIV_LAST = 3'h7;
  localparam logic [1:0] TBK_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBK_RESP_SLVERR = 2'h2;
endpackage : tbk_pkg

// ---- rtl/tbk_timer_bank.sv ----
// Eight 16-bit down-counting timers with flag, mask and priority logic.
// Assumes an AXI4-Lite master on sys_clk_i and asynchronous pin inputs.
`timescale 1ns/1ps
module tbk_timer_bank (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins
  input wire logic fast_clock_i,
  input wire logic external_count_pin_i,
  input wire logic [5:0] edge_irq_i,
  input wire logic level_irq_input_n_i,
  input wire logic [7:0] serial_evt_i,
  // Outputs
  output logic chip_reset_pin_n_o,
  output logic irq_o,
  output logic [4:0] irq_vector_o,
  output logic run_o,
  output logic [1:0] baud_tick_o
);
  typedef struct packed {
    logic [7:0][7:0] tmr_lo;
    logic [7:0][7:0] tmr_hi;
    logic [7:0][7:0] lat_lo;
    logic [7:0][7:0] lat_hi;
    logic [7:0] ctrl;
    logic [7:0] ten;
    logic [7:0] tfl;
    logic [7:0] efl;
    logic [7:0] sfl;
    logic [7:0] tmk;
    logic [7:0] emk;
    logic [7:0] smk;
    logic wd_act;
    logic [1:0] rst_cnt;
    logic rst_n;
    logic irq;
    logic [4:0] vec;
    logic waiting;
    logic run;
    logic [1:0][3:0] bdiv;
    logic [1:0] btick;
    logic fc_s1;
    logic fc_s2;
    logic fc_p;
    logic ex_s1;
    logic ex_s2;
    logic ex_p;
    logic [5:0] eg_s1;
    logic [5:0] eg_s2;
    logic [5:0] eg_p;
    logic lv_s1;
    logic lv_s2;
    logic lv_p;
    logic [2:0] div;
    logic fdiv;
    logic fdiv_p;
    logic ph;
    logic aw_h;
    logic [7:0] aw_a;
    logic w_h;
    logic [7:0] w_d;
    logic w_s;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] bresp;
    logic arr;
    logic rv;
    logic [7:0] rd;
    logic [1:0] rresp;
  } tbk_state_t;

  tbk_state_t s;
  tbk_state_t n;
  logic [7:0] fall;
  logic [7:0] rise;
  logic [7:0] to;
  logic [7:0] wr_hi;
  logic [7:0] tclr;
  logic [7:0] eclr;
  logic [7:0] sclr;
  logic [5:0] eg_ev;
  logic [23:0] fl_all;
  logic [23:0] mk_all;
  logic f_rise;
  logic f_fall;
  logic d_rise;
  logic d_fall;
  logic e_rise;
  logic e_fall;
  logic lv_fell;
  logic do_wr;
  logic hit;
  logic [7:0] rdv;
  logic [2:0] ti;

  always_comb
  begin
    n = s;
    to = '0;
    wr_hi = '0;
    tclr = '0;
    eclr = '0;
    sclr = '0;
    fall = '0;
    rise = '0;
    hit = 1'b0;
    rdv = 8'h00;
    ti = 3'h0;
    // Two-flop synchronisers; edge logic reads only the second stage
    n.fc_s1 = fast_clock_i;
    n.fc_s2 = s.fc_s1;
    n.fc_p = s.fc_s2;
    n.ex_s1 = external_count_pin_i;
    n.ex_s2 = s.ex_s1;
    n.ex_p = s.ex_s2;
    n.eg_s1 = edge_irq_i;
    n.eg_s2 = s.eg_s1;
    n.eg_p = s.eg_s2;
    n.lv_s1 = level_irq_input_n_i;
    n.lv_s2 = s.lv_s1;
    n.lv_p = s.lv_s2;
    f_rise = s.fc_s2 & ~s.fc_p;
    f_fall = ~s.fc_s2 & s.fc_p;
    e_rise = s.ex_s2 & ~s.ex_p;
    e_fall = ~s.ex_s2 & s.ex_p;
    // Fast clock divided by 16: toggle every eighth rising edge
    if (f_rise)
    begin
      n.div = s.div + 3'h1;
      if (s.div == tbk_pkg::TBK_FDIV_LAST)
        n.fdiv = ~s.fdiv;
    end
    n.fdiv_p = s.fdiv;
    d_rise = s.fdiv & ~s.fdiv_p;
    d_fall = ~s.fdiv & s.fdiv_p;
    // Processor clock seen as alternating fall and rise phases
    n.ph = ~s.ph;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 2)
      begin
        fall[i] = s.ph;
        rise[i] = ~s.ph;
      end
      else if (i == 2)
      begin
        fall[i] = d_fall;
        rise[i] = d_rise;
      end
      else if (i == 4 && s.ctrl[tbk_pkg::TBK_CTRL_SRC_BIT])
      begin
        fall[i] = e_fall;
        rise[i] = e_rise;
      end
      else
      begin
        fall[i] = f_fall;
        rise[i] = f_rise;
      end
      if ((i == 0) ? s.wd_act : s.ten[i])
      begin
        if (fall[i])
        begin
          n.tmr_lo[i] = s.tmr_lo[i] - 8'h01;
          if (s.tmr_lo[i] == 8'h00)
            n.tmr_hi[i] = s.tmr_hi[i] - 8'h01;
        end
        if (rise[i] && s.tmr_hi[i] == 8'h00 && s.tmr_lo[i] == 8'h00)
        begin
          to[i] = 1'b1;
          n.tmr_hi[i] = s.lat_hi[i];
          n.tmr_lo[i] = s.lat_lo[i];
        end
      end
    end
    if (to[0])
      n.rst_cnt = tbk_pkg::TBK_WDOG_LOW_CYC;
    else if (s.rst_cnt != 2'h0)
      n.rst_cnt = s.rst_cnt - 2'h1;
    n.rst_n = (n.rst_cnt == 2'h0);
    // baud ticks per sixteen timeouts of timers 3 and 4
    for (int b = 0; b < 2; b++)
    begin
      n.btick[b] = to[3 + b] && (s.bdiv[b] == tbk_pkg::TBK_BAUD_LAST);
      if (to[3 + b])
        n.bdiv[b] = s.bdiv[b] + 4'h1;
    end
    // AXI channels; one write and one read in flight
    if (s.awr && s_axi_awvalid_i)
    begin
      n.aw_h = 1'b1;
      n.aw_a = s_axi_awaddr_i;
    end
    if (s.wr && s_axi_wvalid_i)
    begin
      n.w_h = 1'b1;
      n.w_d = s_axi_wdata_i[7:0];
      n.w_s = s_axi_wstrb_i[0];
    end
    if (s.bv && s_axi_bready_i)
      n.bv = 1'b0;
    do_wr = s.aw_h && s.w_h && !s.bv;
    if (do_wr)
    begin
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
      n.bv = 1'b1;
      hit = (s.aw_a[1:0] == 2'h0) && (s.aw_a <= tbk_pkg::TBK_WAIT);
      n.bresp = hit ? tbk_pkg::TBK_RESP_OKAY : tbk_pkg::TBK_RESP_SLVERR;
      ti = s.aw_a[5:3];
      if (hit && s.w_s)
      begin
        if (s.aw_a <= tbk_pkg::TBK_TMR_LAST)
        begin
          if (s.aw_a[2])
          begin
            // high write loads latch then counters
            n.lat_hi[ti] = s.w_d;
            n.tmr_hi[ti] = s.w_d;
            n.tmr_lo[ti] = s.lat_lo[ti];
            wr_hi[ti] = 1'b1;
          end
          else
            n.lat_lo[ti] = s.w_d;
        end
        else
        begin
          unique case (s.aw_a)
            tbk_pkg::TBK_CTRL: n.ctrl = s.w_d;
            tbk_pkg::TBK_TEN:
            begin
              n.ten = s.w_d;
              // watchdog start and reload on rise
              if (s.w_d[0] && !s.ten[0])
              begin
                n.wd_act = 1'b1;
                n.tmr_hi[0] = s.lat_hi[0];
                n.tmr_lo[0] = s.lat_lo[0];
              end
            end
            tbk_pkg::TBK_TFL: tclr = s.w_d;
            tbk_pkg::TBK_EFL: eclr = s.w_d;
            tbk_pkg::TBK_SFL: sclr = s.w_d;
            tbk_pkg::TBK_TMK: n.tmk = s.w_d;
            tbk_pkg::TBK_EMK: n.emk = s.w_d;
            tbk_pkg::TBK_SMK: n.smk = s.w_d;
            tbk_pkg::TBK_WAIT:
            begin
              if (!s.ctrl[tbk_pkg::TBK_CTRL_EMU_BIT])
                n.waiting = 1'b1;
            end
            default: n.ctrl = s.ctrl;
          endcase
        end
      end
    end
    eg_ev = (s.eg_s2 & ~s.eg_p & tbk_pkg::TBK_EDGE_POS)
      | (~s.eg_s2 & s.eg_p & ~tbk_pkg::TBK_EDGE_POS);
    lv_fell = ~s.lv_s2 & s.lv_p;
    n.tfl = (s.tfl & ~tclr) | to;
    n.sfl = (s.sfl & ~sclr) | serial_evt_i;
    n.efl = (s.efl & ~eclr) | {2'h0, eg_ev};
    // level flag held while input low
    n.efl[tbk_pkg::TBK_LVL_BIT] = (s.efl[tbk_pkg::TBK_LVL_BIT] & ~eclr[tbk_pkg::TBK_LVL_BIT])
      | lv_fell | (s.efl[tbk_pkg::TBK_LVL_BIT] & ~s.lv_s2);
    // last enabled hit in ascending scan wins
    fl_all = {s.sfl, s.efl, s.tfl};
    mk_all = {s.smk, s.emk, s.tmk};
    n.irq = 1'b0;
    n.vec = 5'h00;
    for (int k = 0; k < 24; k++)
    begin
      if (fl_all[k] && mk_all[k])
      begin
        n.irq = 1'b1;
        n.vec = 5'(k);
      end
    end
    if (s.irq)
      n.waiting = 1'b0;
    n.run = ~n.waiting;
    // Read channel; data captured at the address handshake
    if (s.rv && s_axi_rready_i)
      n.rv = 1'b0;
    if (s.arr && s_axi_arvalid_i)
    begin
      n.rv = 1'b1;
      n.rresp = tbk_pkg::TBK_RESP_OKAY;
      ti = s_axi_araddr_i[5:3];
      if (s_axi_araddr_i[1:0] != 2'h0 || s_axi_araddr_i > tbk_pkg::TBK_WAIT)
        n.rresp = tbk_pkg::TBK_RESP_SLVERR;
      else if (s_axi_araddr_i <= tbk_pkg::TBK_TMR_LAST)
        rdv = s_axi_araddr_i[2] ? s.tmr_hi[ti] : s.tmr_lo[ti];
      else
      begin
        unique case (s_axi_araddr_i)
          tbk_pkg::TBK_CTRL: rdv = s.ctrl;
          tbk_pkg::TBK_TEN: rdv = s.ten;
          tbk_pkg::TBK_TFL: rdv = s.tfl;
          tbk_pkg::TBK_EFL: rdv = s.efl;
          tbk_pkg::TBK_SFL: rdv = s.sfl;
          tbk_pkg::TBK_TMK: rdv = s.tmk;
          tbk_pkg::TBK_EMK: rdv = s.emk;
          tbk_pkg::TBK_SMK: rdv = s.smk;
          tbk_pkg::TBK_STAT: rdv = {s.wd_act, s.run, s.irq, s.vec};
          default: rdv = 8'h00;
        endcase
      end
      n.rd = rdv;
    end
    n.awr = !n.aw_h && !n.bv;
    n.wr = !n.w_h && !n.bv;
    n.arr = !n.rv;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.rst_n <= 1'b1;
      s.run <= 1'b1;
      s.awr <= 1'b1;
      s.wr <= 1'b1;
      s.arr <= 1'b1;
      // Idle-high level input, so no false edge at release
      s.lv_s1 <= 1'b1;
      s.lv_s2 <= 1'b1;
      s.lv_p <= 1'b1;
    end
    else
      s <= n;
  end

  assign s_axi_awready_o = s.awr;
  assign s_axi_wready_o = s.wr;
  assign s_axi_bvalid_o = s.bv;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arr;
  assign s_axi_rvalid_o = s.rv;
  assign s_axi_rresp_o = s.rresp;
  assign s_axi_rdata_o = {24'h000000, s.rd};
  assign chip_reset_pin_n_o = s.rst_n;
  assign irq_o = s.irq;
  assign irq_vector_o = s.vec;
  assign run_o = s.run;
  assign baud_tick_o = s.btick;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_wd_low;
    !chip_reset_pin_n_o [*2] ##1 chip_reset_pin_n_o;
  endsequence
  property p_wd_pulse;
    to[0] |=> s_wd_low;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog pulse wrong");
  property p_tmr_flag;
    to[5] |=> s.tfl[5];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) else $error("timer flag not set");
  property p_hi_load;
    wr_hi[3] |=> s.tmr_hi[3] == s.lat_hi[3] && s.tmr_lo[3] == s.lat_lo[3];
  endproperty
  a_hi_load: assert property (p_hi_load) else $error("counter load missed");
  property p_wd_idle;
    !s.wd_act && !do_wr |=> $stable(s.tmr_lo[0]) && !to[0];
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("watchdog ran early");
  property p_edge_set;
    eg_ev[0] |=> s.efl[0];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag lost");
  property p_lvl_hold;
    s.efl[tbk_pkg::TBK_LVL_BIT] && !s.lv_s2 |=> s.efl[tbk_pkg::TBK_LVL_BIT];
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("level flag dropped");
  property p_clear;
    do_wr && s.w_s && s.aw_a == tbk_pkg::TBK_TFL && s.w_d[2] && !to[2] |=> !s.tfl[2];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_prio;
    s.sfl[7] && s.smk[7] |=> irq_o && irq_vector_o == 5'h17;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  property p_irq;
    (fl_all & mk_all) != 24'h000000 |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_run;
    !run_o && irq_o |=> ##1 run_o;
  endproperty
  a_run: assert property (p_run) else $error("run not resumed");
  property p_baud;
    baud_tick_o[0] |-> $past(s.bdiv[0]) == 4'hf && $past(to[3]);
  endproperty
  a_baud: assert property (p_baud) else $error("baud tick rate wrong");
endmodule : tbk_timer_bank

// ---- tb/tbk_pin_model.sv ----
// Pin-side partner: free-running fast oscillator and serial event pulses.
// Assumes the bench requests events on sys_clk_i; pulses last one cycle.
`timescale 1ns/1ps
module tbk_pin_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Requests from bench
  input wire logic [7:0] evt_req_i,
  // Pins toward the block
  output logic fast_clock_o,
  output logic [7:0] serial_evt_o
);
  logic [1:0] div_q;
  // Oscillator runs free; kept below a quarter of sys clock for the sync flops
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q <= 2'h0;
      fast_clock_o <= 1'b0;
      serial_evt_o <= 8'h00;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
        fast_clock_o <= ~fast_clock_o;
      serial_evt_o <= evt_req_i;
    end
  end
endmodule : tbk_pin_model

// ---- tb/timer_bank_with_irq_flags_tb.sv ----
// Self-checking bench for the timer bank: AXI4-Lite tasks, pin stimulus.
// Assumes the pin model drives fast clock and serial events.
`timescale 1ns/1ps
module timer_bank_with_irq_flags_tb;
  logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, ext_pin, lvl_n;
  logic awready, wready, bvalid, arready, rvalid, rpin_n, irq, run, fast_clock;
  logic [7:0] awaddr, araddr, evt_req, sevt;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, baud;
  logic [4:0] vec;
  logic [5:0] edges;
  logic [33:0] exp_r;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] v;
  int num_errors = 0;
  int n_compared = 0;
  int cnt;
  int ticks;
  tbk_timer_bank dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .fast_clock_i(fast_clock), .external_count_pin_i(ext_pin),
    .edge_irq_i(edges), .level_irq_input_n_i(lvl_n), .serial_evt_i(sevt),
    .chip_reset_pin_n_o(rpin_n), .irq_o(irq), .irq_vector_o(vec), .run_o(run),
    .baud_tick_o(baud));
  tbk_pin_model pin_u (.sys_clk_i(sys_clk), .rst_i(rst), .evt_req_i(evt_req),
    .fast_clock_o(fast_clock), .serial_evt_o(sevt));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge sys_clk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    rq.push_back({er, 24'h000000, d});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  task automatic pulse(input logic [7:0] m);
    @(posedge sys_clk);
    evt_req <= m;
    @(posedge sys_clk);
    evt_req <= 8'h00;
    repeat (4) @(posedge sys_clk);
  endtask : pulse
  // Results appear here and are matched against the oldest note
  always @(posedge sys_clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
    begin
      exp_r = rq.pop_front();
      chk("rdata", exp_r, {rresp, rdata});
    end
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end
  // Hang guard, well above the expected run length
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, ext_pin} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    evt_req = 8'h00;
    edges = 6'h00;
    lvl_n = 1'b1;
    void'($urandom(89));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(tbk_pkg::TBK_STAT, 8'h40, tbk_pkg::TBK_RESP_OKAY);
    rd(8'h68, 8'h00, tbk_pkg::TBK_RESP_SLVERR);
    rd(8'h41, 8'h00, tbk_pkg::TBK_RESP_SLVERR);
    wr(8'h68, 8'h5a, tbk_pkg::TBK_RESP_SLVERR);
    wr(8'h08, 8'h05, tbk_pkg::TBK_RESP_OKAY);
    rd(8'h08, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h0c, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    rd(8'h08, 8'h05, tbk_pkg::TBK_RESP_OKAY);
    rd(8'h0c, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_TMK, 8'h02, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_TEN, 8'h02, tbk_pkg::TBK_RESP_OKAY);
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk("irq", 34'h1, {33'h0, irq});
    chk("vector", 34'h01, {29'h0, vec});
    wr(tbk_pkg::TBK_TEN, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h0c, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_TFL, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    rd(tbk_pkg::TBK_TFL, 8'h02, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_TFL, 8'h02, tbk_pkg::TBK_RESP_OKAY);
    rd(tbk_pkg::TBK_TFL, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    chk("irq", 34'h0, {33'h0, irq});
    for (int a = 0; a < 3; a++)
    begin
      v = 8'($urandom);
      wr(8'(tbk_pkg::TBK_TMK + 4 * a), v, tbk_pkg::TBK_RESP_OKAY);
      rd(8'(tbk_pkg::TBK_TMK + 4 * a), v, tbk_pkg::TBK_RESP_OKAY);
      wr(8'(tbk_pkg::TBK_TMK + 4 * a), 8'h00, tbk_pkg::TBK_RESP_OKAY);
    end
    pulse(8'h24);
    chk("irq", 34'h0, {33'h0, irq});
    wr(tbk_pkg::TBK_SMK, 8'hff, tbk_pkg::TBK_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("vector", 34'h15, {29'h0, vec});
    wr(tbk_pkg::TBK_SFL, 8'h20, tbk_pkg::TBK_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("vector", 34'h12, {29'h0, vec});
    wr(tbk_pkg::TBK_SFL, 8'h04, tbk_pkg::TBK_RESP_OKAY);
    // Edge 4 reacts to falling only
    @(posedge sys_clk) edges <= 6'h10;
    repeat (6) @(posedge sys_clk);
    rd(tbk_pkg::TBK_EFL, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    @(posedge sys_clk) edges <= 6'h01;
    repeat (6) @(posedge sys_clk);
    rd(tbk_pkg::TBK_EFL, 8'h11, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_EMK, 8'hff, tbk_pkg::TBK_RESP_OKAY);
    pulse(8'h01);
    chk("vector", 34'h10, {29'h0, vec});
    wr(tbk_pkg::TBK_SFL, 8'h01, tbk_pkg::TBK_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("vector", 34'h0c, {29'h0, vec});
    wr(tbk_pkg::TBK_EFL, 8'h11, tbk_pkg::TBK_RESP_OKAY);
    @(posedge sys_clk) lvl_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(tbk_pkg::TBK_EFL, 8'h40, tbk_pkg::TBK_RESP_OKAY);
    rd(tbk_pkg::TBK_EFL, 8'h40, tbk_pkg::TBK_RESP_OKAY);
    @(posedge sys_clk) lvl_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wr(tbk_pkg::TBK_EFL, 8'h40, tbk_pkg::TBK_RESP_OKAY);
    rd(tbk_pkg::TBK_EFL, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_SMK, 8'h02, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_WAIT, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("run", 34'h0, {33'h0, run});
    pulse(8'h02);
    repeat (4) @(posedge sys_clk);
    chk("run", 34'h1, {33'h0, run});
    wr(tbk_pkg::TBK_SFL, 8'h02, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h00, 8'h03, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h04, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      chk("chip_reset", 34'h1, {33'h0, rpin_n});
    end
    wr(tbk_pkg::TBK_TEN, 8'h01, tbk_pkg::TBK_RESP_OKAY);
    for (int i = 0; i < 300 && rpin_n !== 1'b0; i++) @(posedge sys_clk);
    chk("chip_reset", 34'h0, {33'h0, rpin_n});
    @(posedge sys_clk);
    chk("chip_reset", 34'h0, {33'h0, rpin_n});
    @(posedge sys_clk);
    chk("chip_reset", 34'h1, {33'h0, rpin_n});
    // baud timers set up first; timer 4 on the pin
    wr(8'h18, 8'h01, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h1c, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h20, 8'h01, tbk_pkg::TBK_RESP_OKAY);
    wr(8'h24, 8'h00, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_CTRL, 8'h01, tbk_pkg::TBK_RESP_OKAY);
    wr(tbk_pkg::TBK_TEN, 8'h18, tbk_pkg::TBK_RESP_OKAY);
    // Fast clock period is 8 sys cycles in the pin model
    for (int i = 0; i < 300 && baud[0] !== 1'b1; i++) @(posedge sys_clk);
    cnt = 0;
    ticks = 0;
    do
    begin
      @(posedge sys_clk);
      cnt++;
      if (baud[1] === 1'b1)
        ticks++;
    end
    while (baud[0] !== 1'b1 && cnt < 300);
    chk("baud_period", 34'((tbk_pkg::TBK_BAUD_LAST + 1) * 8), 34'(cnt));
    chk("pin_idle_ticks", 34'h0, 34'(ticks));
    // Seventeen pin pulses give sixteen timeouts of timer 4
    for (int p = 0; p < 17; p++)
    begin
      @(posedge sys_clk) ext_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (baud[1] === 1'b1)
        ticks++;
      ext_pin <= 1'b0;
      repeat (4)
      begin
        @(posedge sys_clk);
        if (baud[1] === 1'b1)
          ticks++;
      end
    end
    repeat (8)
    begin
      @(posedge sys_clk);
      if (baud[1] === 1'b1)
        ticks++;
    end
    chk("pin_ticks", 34'h1, 34'(ticks));
    tally_and_finish();
  end
endmodule : timer_bank_with_irq_flags_tb
